// ### rtl/clock_divider.sv
`timescale 1ns/1ps
`default_nettype none
module clock_divider #(
  parameter int DIVIDE = 1024
) (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  output logic      tick
);
  localparam int W = $clog2(DIVIDE);
  logic [W-1:0] count_q;

  if (DIVIDE < 2)
  begin
    $error("clock_divider: DIVIDE must be at least 2");
  end

  // One tick per half converter clock period
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      count_q <= '0;
      tick    <= 1'b0;
    end
    else if (clk_en)
    begin
      tick <= (count_q == W'(DIVIDE - 1));
      if (count_q == W'(DIVIDE - 1))
        count_q <= '0;
      else
        count_q <= count_q + W'(1);
    end
  end
endmodule
`default_nettype wire

// ### rtl/monitor_converter_params.svh
`ifndef MONITOR_CONVERTER_PARAMS_SVH
`define MONITOR_CONVERTER_PARAMS_SVH
`define MC_ADDR_W            3
`define MC_ADDR_CONVERTER    3'h0
`define MC_ADDR_SELECT       3'h1
`define MC_ADDR_PULSE        3'h2
`define MC_ADDR_RESULT       3'h3
`define MC_ADDR_REGULATOR    3'h4
`define MC_ADDR_BOTTOM       3'h5
`define MC_ADDR_STATUS       3'h6
`define MC_TRIM_LSB          0
`define MC_TRIM_MSB          5
`define MC_REF_LSB           6
`define MC_REF_MSB           8
`define MC_REF_PAD           3'h0
`define MC_REF_RES_A         3'h1
`define MC_REF_RES_B         3'h2
`define MC_SEL_ENABLE_BIT    12
`define MC_SEL_CHAN_MSB      11
`define MC_PULSE_SOC_BIT     0
`define MC_DR_EN_BIT         11
`define MC_DR_CODE_MSB       10
`define MC_DR_CODE_LSB       7
`define MC_DR_BIAS_BIT       6
`define MC_AN_EN_BIT         5
`define MC_AN_CODE_MSB       4
`define MC_AN_CODE_LSB       1
`define MC_AN_BIAS_BIT       0
`define MC_CONVERTER_RESET   9'h000
`define MC_SELECT_RESET      13'h0000
`define MC_SENSOR_RESET      12'h000
`define MC_CONV_PERIODS      14
`define MC_CLOCK_DIVIDE      1024
`endif

// ### rtl/monitor_converter_pkg.sv
package monitor_converter_pkg;
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_SYNC = 2'b01,
    ST_CONV = 2'b10
  } conv_state_type;
endpackage

// ### rtl/monitor_converter_sensor_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "monitor_converter_params.svh"
// How it works
// - Low six bits of converter config drive the capacitor trim code.
// - Top three config bits pick reference; default is the pad reference.
// - Monitoring enable bit resets to zero, block disabled.
// - Writing a one to bit 0 of the pulse register issues a start pulse that begins conversion.
// - Active-low done flag falls when result ready; also sent to debug output.
// - A conversion lasts fourteen divider ticks, which is seven converter clock periods.
// - Result holds the same value until the next conversion finishes.
// - Reading the result has no side effect on the converter.
// - Result is a full twelve-bit code, also in differential mode.
// - Sixteen equal sources; matching code selects one of sixteen assignments.
// - Two sensor registers: twelve-bit regulators and six-bit bottom centre.
// - Regulator register: bit 11 enable, bits 10-7 code, bit 6 bias.
// - Both sensor registers: bit 5 enable, bits 4-1 code, bit 0 bias.
// - Bias bit zero gives unit current, one gives fifteen times.
// - Resistive sensors have no bits; used only via reference selection.
// - Converter clock is the bunch crossing clock divided by 2048, toggling every 1024 cycles.
module monitor_converter_sensor_control #(
  parameter int DIVIDE  = `MC_CLOCK_DIVIDE,
  parameter int PERIODS = `MC_CONV_PERIODS
) (
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  clk_en,
  input  wire logic [`MC_ADDR_W-1:0] reg_addr,
  input  wire logic [15:0]           reg_wdata,
  input  wire logic                  reg_write,
  input  wire logic                  reg_read,
  output logic      [15:0]           reg_rdata,
  input  wire logic [11:0]           converter_code,
  output logic      [5:0]            cap_trim,
  output logic      [2:0]            reference_select,
  output logic                       monitor_enable,
  output logic      [11:0]           channel_select,
  output logic                       converter_clk,
  output logic                       conversion_start,
  output logic                       conversion_done_n,
  output logic                       debug_done_n,
  output logic                       digital_reg_sensor_enable,
  output logic      [15:0]           digital_reg_source_sel,
  output logic                       digital_reg_bias_select,
  output logic                       analog_sensor_enable,
  output logic      [15:0]           analog_source_sel,
  output logic                       analog_bias_select,
  output logic                       bottom_sensor_enable,
  output logic      [15:0]           bottom_source_sel,
  output logic                       bottom_bias_select
);
  localparam int CW = $clog2(PERIODS + 1);

  logic [8:0]                              converter_config_q;
  logic [12:0]                             monitor_select_config_q;
  logic [11:0]                             regulator_sensor_config_q;
  logic [11:0]                             bottom_sensor_config_q;
  logic [11:0]                             conversion_result_q;
  logic [11:0]                             code_meta_q;
  logic [11:0]                             code_sync_q;
  logic [CW-1:0]                           period_q;
  logic                                    tick;
  logic                                    wr_pulse;
  monitor_converter_pkg::conv_state_type   state_q;

  if (PERIODS < 1 || DIVIDE < 2)
  begin
    $error("monitor_converter_sensor_control: bad PERIODS or DIVIDE");
  end

  // One-hot current source assignment from a matching code
  function automatic logic [15:0] source_decode(input logic [3:0] code);
    source_decode = 16'h0001 << code;
  endfunction

  clock_divider #(
    .DIVIDE (DIVIDE)
  ) u_divider (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .tick     (tick)
  );

  assign wr_pulse     = reg_write && (reg_addr == `MC_ADDR_PULSE) && reg_wdata[`MC_PULSE_SOC_BIT];

  // Configuration registers
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      converter_config_q        <= `MC_CONVERTER_RESET;
      monitor_select_config_q   <= `MC_SELECT_RESET;
      regulator_sensor_config_q <= `MC_SENSOR_RESET;
      bottom_sensor_config_q    <= `MC_SENSOR_RESET;
    end
    else if (clk_en && reg_write)
    begin
      case (reg_addr)
        `MC_ADDR_CONVERTER: converter_config_q <= reg_wdata[8:0];
        `MC_ADDR_SELECT:    monitor_select_config_q <= reg_wdata[12:0];
        `MC_ADDR_REGULATOR: regulator_sensor_config_q <= reg_wdata[11:0];
        `MC_ADDR_BOTTOM:    bottom_sensor_config_q <= {6'h00, reg_wdata[5:0]};
        default:            ;
      endcase
    end
  end

  // Converter input code from the analog side
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      code_meta_q <= 12'h000;
      code_sync_q <= 12'h000;
    end
    else if (clk_en)
    begin
      code_meta_q <= converter_code;
      code_sync_q <= code_meta_q;
    end
  end

  // Conversion sequence
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_q             <= monitor_converter_pkg::ST_IDLE;
      period_q            <= '0;
      conversion_result_q <= 12'h000;
      conversion_done_n   <= 1'b1;
      conversion_start    <= 1'b0;
    end
    else if (clk_en)
    begin
      conversion_start <= 1'b0;
      if (wr_pulse)
      begin
        state_q           <= monitor_converter_pkg::ST_SYNC;
        conversion_done_n <= 1'b1;
        period_q          <= '0;
      end
      else
      begin
        case (state_q)
          monitor_converter_pkg::ST_IDLE: ;
          monitor_converter_pkg::ST_SYNC:
            if (tick)
            begin
              state_q          <= monitor_converter_pkg::ST_CONV;
              conversion_start <= 1'b1;
              period_q         <= '0;
            end
          monitor_converter_pkg::ST_CONV:
            if (tick)
            begin
              if (period_q == CW'(PERIODS - 1))
              begin
                state_q             <= monitor_converter_pkg::ST_IDLE;
                conversion_result_q <= code_sync_q;
                conversion_done_n   <= 1'b0;
              end
              else
                period_q <= period_q + CW'(1);
            end
          default: state_q <= monitor_converter_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // Register read path; reads change no state
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      reg_rdata <= 16'h0000;
    else if (clk_en)
    begin
      reg_rdata <= 16'h0000;
      if (reg_read)
      begin
        case (reg_addr)
          `MC_ADDR_CONVERTER: reg_rdata <= {7'h00, converter_config_q};
          `MC_ADDR_SELECT:    reg_rdata <= {3'h0, monitor_select_config_q};
          `MC_ADDR_RESULT:    reg_rdata <= {4'h0, conversion_result_q};
          `MC_ADDR_REGULATOR: reg_rdata <= {4'h0, regulator_sensor_config_q};
          `MC_ADDR_BOTTOM:    reg_rdata <= {4'h0, bottom_sensor_config_q};
          `MC_ADDR_STATUS:    reg_rdata <= {13'h0000, state_q, conversion_done_n};
          default:            reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // Registered outputs to converter and sensors
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cap_trim                  <= 6'h00;
      reference_select          <= `MC_REF_PAD;
      monitor_enable            <= 1'b0;
      channel_select            <= 12'h000;
      converter_clk             <= 1'b0;
      debug_done_n              <= 1'b1;
      digital_reg_sensor_enable <= 1'b0;
      digital_reg_source_sel    <= 16'h0001;
      digital_reg_bias_select   <= 1'b0;
      analog_sensor_enable      <= 1'b0;
      analog_source_sel         <= 16'h0001;
      analog_bias_select        <= 1'b0;
      bottom_sensor_enable      <= 1'b0;
      bottom_source_sel         <= 16'h0001;
      bottom_bias_select        <= 1'b0;
    end
    else if (clk_en)
    begin
      cap_trim                  <= converter_config_q[`MC_TRIM_MSB:`MC_TRIM_LSB];
      reference_select          <= converter_config_q[`MC_REF_MSB:`MC_REF_LSB];
      monitor_enable            <= monitor_select_config_q[`MC_SEL_ENABLE_BIT];
      channel_select            <= monitor_select_config_q[`MC_SEL_CHAN_MSB:0];
      if (tick)
        converter_clk <= ~converter_clk;
      debug_done_n              <= conversion_done_n;
      digital_reg_sensor_enable <= regulator_sensor_config_q[`MC_DR_EN_BIT];
      digital_reg_source_sel    <= source_decode(regulator_sensor_config_q[`MC_DR_CODE_MSB:`MC_DR_CODE_LSB]);
      digital_reg_bias_select   <= regulator_sensor_config_q[`MC_DR_BIAS_BIT];
      analog_sensor_enable      <= regulator_sensor_config_q[`MC_AN_EN_BIT];
      analog_source_sel         <= source_decode(regulator_sensor_config_q[`MC_AN_CODE_MSB:`MC_AN_CODE_LSB]);
      analog_bias_select        <= regulator_sensor_config_q[`MC_AN_BIAS_BIT];
      bottom_sensor_enable      <= bottom_sensor_config_q[`MC_AN_EN_BIT];
      bottom_source_sel         <= source_decode(bottom_sensor_config_q[`MC_AN_CODE_MSB:`MC_AN_CODE_LSB]);
      bottom_bias_select        <= bottom_sensor_config_q[`MC_AN_BIAS_BIT];
    end
  end

  property p_reset_disabled;
    @(posedge core_clk) $fell(sys_rst) |-> !monitor_select_config_q[`MC_SEL_ENABLE_BIT];
  endproperty
  a_reset_disabled: assert property (p_reset_disabled) else $error("monitor enable not zero after reset");

  property p_pulse_clears_done;
    @(posedge core_clk) disable iff (sys_rst) (clk_en && wr_pulse) |=> conversion_done_n;
  endproperty
  a_pulse_clears_done: assert property (p_pulse_clears_done) else $error("done flag not raised by start");

  property p_start_on_tick;
    @(posedge core_clk) disable iff (sys_rst)
      (clk_en && tick && state_q == monitor_converter_pkg::ST_SYNC && !wr_pulse) |=> conversion_start;
  endproperty
  a_start_on_tick: assert property (p_start_on_tick) else $error("start pulse missing");

  property p_done_only_at_end;
    @(posedge core_clk) disable iff (sys_rst)
      $fell(conversion_done_n) |-> $past(state_q) == monitor_converter_pkg::ST_CONV
        && $past(period_q) == CW'(PERIODS - 1);
  endproperty
  a_done_only_at_end: assert property (p_done_only_at_end) else $error("done before fourteen periods");

  property p_result_stable;
    @(posedge core_clk) disable iff (sys_rst) !$fell(conversion_done_n) |-> $stable(conversion_result_q);
  endproperty
  a_result_stable: assert property (p_result_stable) else $error("result changed without conversion");

  property p_read_no_effect;
    @(posedge core_clk) disable iff (sys_rst)
      (reg_read && state_q == monitor_converter_pkg::ST_IDLE && !wr_pulse) |=> state_q == monitor_converter_pkg::ST_IDLE;
  endproperty
  a_read_no_effect: assert property (p_read_no_effect) else $error("read started a conversion");

  property p_debug_follows;
    @(posedge core_clk) disable iff (sys_rst) clk_en |=> debug_done_n == $past(conversion_done_n);
  endproperty
  a_debug_follows: assert property (p_debug_follows) else $error("debug flag wrong");

  property p_bottom_upper_zero;
    @(posedge core_clk) disable iff (sys_rst) bottom_sensor_config_q[11:6] == 6'h00;
  endproperty
  a_bottom_upper_zero: assert property (p_bottom_upper_zero) else $error("bottom sensor upper bits set");

  property p_start_single;
    @(posedge core_clk) disable iff (sys_rst) (clk_en && conversion_start) |=> !conversion_start;
  endproperty
  a_start_single: assert property (p_start_single) else $error("start pulse longer than one cycle");

  property p_trim_follows;
    @(posedge core_clk) disable iff (sys_rst)
      clk_en |=> cap_trim == $past(converter_config_q[`MC_TRIM_MSB:`MC_TRIM_LSB]);
  endproperty
  a_trim_follows: assert property (p_trim_follows) else $error("trim code not driven");

  property p_conv_clk_toggle;
    @(posedge core_clk) disable iff (sys_rst) (clk_en && tick) |=> converter_clk != $past(converter_clk);
  endproperty
  a_conv_clk_toggle: assert property (p_conv_clk_toggle) else $error("converter clock did not toggle");

  c_conversion: cover property (@(posedge core_clk) $fell(conversion_done_n));
  c_restart: cover property (@(posedge core_clk) conversion_start ##[1:300] wr_pulse);
  c_result_read: cover property (@(posedge core_clk) reg_read && reg_addr == `MC_ADDR_RESULT && !conversion_done_n);
endmodule
`default_nettype wire

// ### test/tb_monitor_converter_sensor_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "monitor_converter_params.svh"
module tb_monitor_converter_sensor_control;
  localparam int SIM_DIV = 4;
  localparam int PER     = `MC_CONV_PERIODS;
  logic                  core_clk = 1'b0;
  logic                  sys_rst = 1'b1;
  logic                  clk_en = 1'b1;
  logic [`MC_ADDR_W-1:0] reg_addr = '0;
  logic [15:0]           reg_wdata = 16'h0000;
  logic                  reg_write = 1'b0;
  logic                  reg_read = 1'b0;
  logic [15:0]           reg_rdata;
  logic [11:0]           converter_code = 12'h000;
  logic [5:0]            cap_trim;
  logic [2:0]            reference_select;
  logic                  monitor_enable;
  logic [11:0]           channel_select;
  logic                  converter_clk;
  logic                  conversion_start;
  logic                  conversion_done_n;
  logic                  debug_done_n;
  logic                  digital_reg_sensor_enable;
  logic [15:0]           digital_reg_source_sel;
  logic                  digital_reg_bias_select;
  logic                  analog_sensor_enable;
  logic [15:0]           analog_source_sel;
  logic                  analog_bias_select;
  logic                  bottom_sensor_enable;
  logic [15:0]           bottom_source_sel;
  logic                  bottom_bias_select;
  int                    mismatches = 0;
  int                    comparisons = 0;
  logic [15:0]           rd;
  always #50 core_clk = ~core_clk;
  monitor_converter_sensor_control #(.DIVIDE(SIM_DIV), .PERIODS(PER)) i_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .converter_code(converter_code), .cap_trim(cap_trim), .reference_select(reference_select),
    .monitor_enable(monitor_enable), .channel_select(channel_select), .converter_clk(converter_clk),
    .conversion_start(conversion_start), .conversion_done_n(conversion_done_n),
    .debug_done_n(debug_done_n), .digital_reg_sensor_enable(digital_reg_sensor_enable),
    .digital_reg_source_sel(digital_reg_source_sel), .digital_reg_bias_select(digital_reg_bias_select),
    .analog_sensor_enable(analog_sensor_enable), .analog_source_sel(analog_source_sel),
    .analog_bias_select(analog_bias_select), .bottom_sensor_enable(bottom_sensor_enable),
    .bottom_source_sel(bottom_source_sel), .bottom_bias_select(bottom_bias_select));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic reg_wr(input logic [`MC_ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask
  task automatic reg_rd(input logic [`MC_ADDR_W-1:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic settle();
    @(posedge core_clk);
    #1;
  endtask
  task automatic test_reset();
    reg_rd(`MC_ADDR_SELECT, rd);
    check("select", rd, 16'h0000);
    check("monitor_enable", {15'h0000, monitor_enable}, 16'h0000);
    check("done_n", {15'h0000, conversion_done_n}, 16'h0001);
    check("debug_done_n", {15'h0000, debug_done_n}, 16'h0001);
    reg_rd(`MC_ADDR_CONVERTER, rd);
    check("converter", rd, 16'h0000);
    check("reference", {13'h0000, reference_select}, {13'h0000, `MC_REF_PAD});
    check("analog_source_sel", analog_source_sel, 16'h0001);
  endtask
  task automatic test_converter_cfg();
    logic [8:0] v;
    for (int r = 0; r < 3; r++)
    begin
      v = {r[2:0], 6'h2A ^ r[5:0]};
      reg_wr(`MC_ADDR_CONVERTER, {7'h00, v});
      settle();
      check("cap_trim", {10'h000, cap_trim}, {10'h000, v[5:0]});
      check("reference", {13'h0000, reference_select}, {13'h0000, v[8:6]});
      reg_rd(`MC_ADDR_CONVERTER, rd);
      check("converter", rd, {7'h00, v});
    end
  endtask
  task automatic test_select();
    reg_wr(`MC_ADDR_SELECT, 16'h100E);
    settle();
    check("monitor_enable", {15'h0000, monitor_enable}, 16'h0001);
    check("channel", {4'h0, channel_select}, 16'h000E);
    reg_rd(`MC_ADDR_SELECT, rd);
    check("select", rd, 16'h100E);
  endtask
  task automatic test_sensors();
    reg_wr(`MC_ADDR_REGULATOR, 16'h0D5B);
    settle();
    check("dreg_en", {15'h0000, digital_reg_sensor_enable}, 16'h0001);
    check("dreg_sel", digital_reg_source_sel, 16'h0400);
    check("dreg_bias", {15'h0000, digital_reg_bias_select}, 16'h0001);
    check("an_en", {15'h0000, analog_sensor_enable}, 16'h0000);
    check("an_sel", analog_source_sel, 16'h2000);
    check("an_bias", {15'h0000, analog_bias_select}, 16'h0001);
    reg_rd(`MC_ADDR_REGULATOR, rd);
    check("regulator", rd, 16'h0D5B);
    reg_wr(`MC_ADDR_BOTTOM, 16'h0FFF);
    settle();
    check("bot_en", {15'h0000, bottom_sensor_enable}, 16'h0001);
    check("bot_sel", bottom_source_sel, 16'h8000);
    check("bot_bias", {15'h0000, bottom_bias_select}, 16'h0001);
    reg_rd(`MC_ADDR_BOTTOM, rd);
    check("bottom", rd, 16'h003F);
    for (int b = 0; b < 2; b++)
    begin
      for (int c = 0; c < 16; c++)
      begin
        reg_wr(`MC_ADDR_REGULATOR, {10'h000, 1'b1, c[3:0], b[0]});
        settle();
        check("an_en_sweep", {15'h0000, analog_sensor_enable}, 16'h0001);
        check("an_sel_sweep", analog_source_sel, 16'h0001 << c);
        check("an_bias_sweep", {15'h0000, analog_bias_select}, {15'h0000, b[0]});
      end
    end
  endtask
  task automatic test_conversion(input logic [11:0] code);
    int n;
    converter_code <= code;
    reg_wr(`MC_ADDR_PULSE, 16'h0001);
    settle();
    check("done_n_restart", {15'h0000, conversion_done_n}, 16'h0001);
    n = 0;
    while (conversion_start !== 1'b1 && n < 4 * SIM_DIV)
    begin
      settle();
      n++;
    end
    check("start_seen", {15'h0000, conversion_start}, 16'h0001);
    n = 0;
    while (conversion_done_n !== 1'b0 && n < 20 * SIM_DIV)
    begin
      settle();
      n++;
    end
    check("conv_long", {15'h0000, n >= (PER - 1) * SIM_DIV}, 16'h0001);
    check("conv_short", {15'h0000, n <= (PER + 1) * SIM_DIV}, 16'h0001);
    check("debug_lag", {15'h0000, debug_done_n}, 16'h0001);
    settle();
    check("debug_done_n", {15'h0000, debug_done_n}, 16'h0000);
    reg_rd(`MC_ADDR_RESULT, rd);
    check("result", rd, {4'h0, code});
  endtask
  task automatic test_hold(input logic [11:0] code);
    converter_code <= ~code;
    for (int i = 0; i < 3; i++)
    begin
      reg_rd(`MC_ADDR_RESULT, rd);
      check("result_hold", rd, {4'h0, code});
      check("done_n_hold", {15'h0000, conversion_done_n}, 16'h0000);
      check("no_start", {15'h0000, conversion_start}, 16'h0000);
    end
    reg_wr(`MC_ADDR_RESULT, 16'hFFFF);
    reg_rd(7, rd);
    check("unmapped", rd, 16'h0000);
    reg_rd(`MC_ADDR_RESULT, rd);
    check("result_ro", rd, {4'h0, code});
    reg_rd(`MC_ADDR_STATUS, rd);
    check("status", rd, {13'h0000, monitor_converter_pkg::ST_IDLE, 1'b0});
  endtask
  task automatic test_clock();
    int n;
    logic prev;
    settle();
    prev = converter_clk;
    while (converter_clk === prev)
      settle();
    prev = converter_clk;
    n = 0;
    while (converter_clk === prev && n < 4 * SIM_DIV)
    begin
      settle();
      n++;
    end
    check("conv_clk_half", n[15:0], 16'(SIM_DIV));
  endtask
  task automatic test_freeze();
    logic prev;
    @(posedge core_clk);
    clk_en <= 1'b0;
    settle();
    prev = converter_clk;
    reg_wr(`MC_ADDR_SELECT, 16'h0000);
    repeat (2 * SIM_DIV) settle();
    check("frozen_clk", {15'h0000, converter_clk}, {15'h0000, prev});
    check("frozen_enable", {15'h0000, monitor_enable}, 16'h0001);
    @(posedge core_clk);
    clk_en <= 1'b1;
    reg_rd(`MC_ADDR_SELECT, rd);
    check("frozen_select", rd, 16'h100E);
  endtask
  task automatic test_disable();
    reg_wr(`MC_ADDR_SELECT, 16'h000E);
    settle();
    check("monitor_off", {15'h0000, monitor_enable}, 16'h0000);
    check("channel_kept", {4'h0, channel_select}, 16'h000E);
  endtask
  initial
  begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    test_reset();
    test_converter_cfg();
    test_select();
    test_freeze();
    test_sensors();
    test_clock();
    test_conversion(12'hA5C);
    test_hold(12'hA5C);
    test_conversion(12'hFFF);
    test_conversion(12'h001);
    test_disable();
    give_verdict();
  end
  initial
  begin
    #1_000_000;
    mismatches++;
    give_verdict();
  end
endmodule
`default_nettype wire
